// File: rtl/tohg_defs.svh
// Constants of the transmit overhead generator: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design file.
`ifndef TOHG_DEFS_SVH
`define TOHG_DEFS_SVH
`define TOHG_A_DIAG     7'h14
`define TOHG_A_RXALM    7'h45
`define TOHG_A_ST1      7'h47
`define TOHG_A_ST3      7'h49
`define TOHG_A_TLIU     7'h68
`define TOHG_A_TX_CONFIG_ZERO     7'h70
`define TOHG_A_TX_FRAME_FORMAT     7'h72
`define TOHG_A_TX_MANUAL_OVERHEAD_CONFIG     7'h74
`define TOHG_A_TX_ALARM_CONFIG     7'h75
`define TOHG_RST        8'h00
// Field positions
`define TOHG_B_FMT_HI   2
`define TOHG_B_INCF     3
`define TOHG_B_JAPANESE_SF_YELLOW     4
`define TOHG_B_FBIT     0
`define TOHG_B_MF       1
`define TOHG_B_CRC      2
`define TOHG_B_YEL      3
`define TOHG_B_MYEL     4
`define TOHG_B_AFE      5
`define TOHG_B_MANUAL_AIS     0
`define TOHG_B_AAIS     1
`define TOHG_B_MANUAL_YELLOW     2
`define TOHG_B_AYEL     3
`define TOHG_B_MANUAL_MF_YELLOW    4
`define TOHG_B_AMYEL    5
// Frame patterns, CRC polynomial and last bit positions
`define TOHG_FS_PAT     6'h0E
`define TOHG_FPS_PAT    6'h0B
`define TOHG_MF_PAT     6'h0B
`define TOHG_FAS_PAT    8'h1B
`define TOHG_CRC_POLY   6'h03
`define TOHG_T1_LAST    8'hC0
`define TOHG_E1_LAST    8'hFF
// Timing
`define TOHG_CLK_HZ     10000000
`define TOHG_LOF_INT_MS 2500
`define TOHG_YEL_HLD_MS 1000
`define TOHG_LOF_INT_CY (`TOHG_LOF_INT_MS * (`TOHG_CLK_HZ / 1000))
`define TOHG_YEL_HLD_CY (`TOHG_YEL_HLD_MS * (`TOHG_CLK_HZ / 1000))
`define TOHG_LOC_CYC    4'h8
`endif

// File: rtl/tohg_pkg.sv
// Types of the transmit overhead generator.
// Assumes nothing beyond a SystemVerilog compiler.
package tohg_pkg;
   typedef enum logic [2:0] {FMT_SF, FMT_ESF, FMT_LC, FMT_T1DM, FMT_E1, FMT_E1CAS} tohg_fmt_e;
endpackage

// File: rtl/tohg_tx_overhead.sv
// Transmit overhead generator for one T1/E1 channel: framing, AIS, yellow, CRC, FEBE.
// Assumes register port on CLK, data path on TX_CLOCK_IN, AIS clock on the alternate pins.
// Behaviour
// - Ft pattern in SF, loop-carrier, T1DM frame bits
// - Fs in SF, MFAS in E1 when enabled
// - FPS in ESF, FAS/NFAS in E1
// - Manual AIS sends unframed all ones
// - Manual AIS clocked by alternate clock when selected
// - Eight alternate cycles without edges flag loss when selected
// - Returning transmit clock clears loss and AIS
// - Receive signal loss sends AIS when enabled
// - Yellow forces bit 2 of slots low in SF, ESF and loop-carrier
// - Japanese, T1DM and E1 yellow positions
// - Auto yellow written only with insert enabled
// - Manual yellow forces pattern unconditionally
// - Auto yellow follows receive frame loss
// - Integration delays loss; yellow holds one second
// - E1 CAS multiframe yellow in TS16 frame 0
// - Manual multiframe yellow forced unconditionally
// - Auto multiframe yellow follows CAS alignment loss
// - CRC-6 in ESF, CRC-4 in E1
// - CRC-6 includes F-bit when option set
// - A received CRC error sends the next E-bit zero
// - Manual E-bits from processor fields
`timescale 1ns/1ns
`include "tohg_defs.svh"
module tohg_tx_overhead
   import tohg_pkg::*;
#(
   parameter int INTEG_CYCLES = `TOHG_LOF_INT_CY,
   parameter int HOLD_CYCLES  = `TOHG_YEL_HLD_CY
) (
   input  wire logic       CLK,
   input  wire logic       RESET,
   input  wire logic [6:0] ADDR,
   input  wire logic [7:0] WR_DATA,
   input  wire logic       WR_EN,
   input  wire logic       RD_EN,
   output logic      [7:0] RD_DATA,
   input  wire logic       RX_SIGNAL_LOSS,
   input  wire logic       RX_FRAME_LOSS,
   input  wire logic       RX_CAS_MF_LOSS,
   input  wire logic       RX_CRC_ERROR,
   output logic            LINE_LOOPBACK,
   output logic            TX_CLOCK_LOSS_FLAG,
   input  wire logic       TX_CLOCK_IN,
   input  wire logic       SYSTEM_PCM_TX_IN,
   output logic            LINE_DATA,
   output logic            FRAME_START,
   input  wire logic       ALT_CLOCK_IN_E1,
   input  wire logic       ALT_CLOCK_IN_T1,
   output logic            ALT_DATA,
   output logic            ALT_ACTIVE
);
   function automatic logic sel6(input logic [5:0] p, input logic [2:0] k);
      sel6 = p[3'd5 - k];
   endfunction
   // One CRC step; CRC-4 uses the low four bits of the same register
   function automatic logic [5:0] crc_step(input logic [5:0] c, input logic d,
                                           input logic e1);
      logic       fb;
      logic [5:0] n;
      fb = (e1 ? c[3] : c[5]) ^ d;
      n  = {c[4:0], 1'b0} ^ (fb ? `TOHG_CRC_POLY : 6'h00);
      crc_step = e1 ? {2'b00, n[3:0]} : n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register port and receive status synchronisers (CLK)
   logic [7:0]  diag_r, rxalm_r, tliu_r, tx_config_zero_r, tx_frame_format_r, tx_manual_overhead_config_r, tx_alarm_config_r, rd_r;
   logic [3:0]  rx_s1_r, rx_s2_r;
   logic        crc_d_r, crc_tog_r, loc_s1_r, loc_s2_r;
   logic [31:0] lof_cnt_r, hold_r;
   logic        lof_flag_r, a_loss_r, l_tog_r;
   logic [14:0] cfg_c_r;
   wire         rls   = rx_s2_r[0];
   wire         raw   = rx_s2_r[1];
   wire         cas_l = rx_s2_r[2];
   wire         integ = rxalm_r[0];
   wire         yel_auto = integ ? (lof_flag_r | (hold_r != 32'h0)) : raw;
   wire         lof_st   = integ ? lof_flag_r : raw;
   wire         yel_on = tx_alarm_config_r[`TOHG_B_MANUAL_YELLOW]
                      | (tx_frame_format_r[`TOHG_B_YEL] & tx_alarm_config_r[`TOHG_B_AYEL] & yel_auto);
   wire         myel_on = tx_alarm_config_r[`TOHG_B_MANUAL_MF_YELLOW]
                       | (tx_frame_format_r[`TOHG_B_MYEL] & tx_alarm_config_r[`TOHG_B_AMYEL] & cas_l);
   wire         ais_req = tx_alarm_config_r[`TOHG_B_MANUAL_AIS] | (tx_alarm_config_r[`TOHG_B_AAIS] & rls);
   wire [14:0]  cfg_nxt = {tx_frame_format_r[`TOHG_B_AFE], tx_manual_overhead_config_r[2:0], ais_req, myel_on, yel_on,
                           tx_config_zero_r[`TOHG_B_JAPANESE_SF_YELLOW], tx_config_zero_r[`TOHG_B_INCF],
                           tx_frame_format_r[`TOHG_B_CRC], tx_frame_format_r[`TOHG_B_MF], tx_frame_format_r[`TOHG_B_FBIT],
                           tx_config_zero_r[`TOHG_B_FMT_HI:0]};
   wire         we_diag  = WR_EN && (ADDR == `TOHG_A_DIAG);
   wire         we_rxalm = WR_EN && (ADDR == `TOHG_A_RXALM);
   wire         we_tliu  = WR_EN && (ADDR == `TOHG_A_TLIU);
   wire         we_tx_config_zero  = WR_EN && (ADDR == `TOHG_A_TX_CONFIG_ZERO);
   wire         we_tx_frame_format  = WR_EN && (ADDR == `TOHG_A_TX_FRAME_FORMAT);
   wire         we_tx_manual_overhead_config  = WR_EN && (ADDR == `TOHG_A_TX_MANUAL_OVERHEAD_CONFIG);
   wire         we_tx_alarm_config  = WR_EN && (ADDR == `TOHG_A_TX_ALARM_CONFIG);
   wire [7:0]   rd_nxt =
      (ADDR == `TOHG_A_DIAG)  ? diag_r  : (ADDR == `TOHG_A_RXALM) ? rxalm_r :
      (ADDR == `TOHG_A_ST1)   ? {5'h00, loc_s2_r, lof_st, rls} :
      (ADDR == `TOHG_A_ST3)   ? {7'h00, cas_l} :
      (ADDR == `TOHG_A_TLIU)  ? tliu_r  : (ADDR == `TOHG_A_TX_CONFIG_ZERO)  ? tx_config_zero_r  :
      (ADDR == `TOHG_A_TX_FRAME_FORMAT)  ? tx_frame_format_r  : (ADDR == `TOHG_A_TX_MANUAL_OVERHEAD_CONFIG)  ? tx_manual_overhead_config_r  :
      (ADDR == `TOHG_A_TX_ALARM_CONFIG)  ? tx_alarm_config_r  : 8'h00;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         {diag_r, rxalm_r, tliu_r, tx_config_zero_r} <= {4{`TOHG_RST}};
         {tx_frame_format_r, tx_manual_overhead_config_r, tx_alarm_config_r, rd_r}   <= {4{`TOHG_RST}};
      end else begin
         if (we_diag)  diag_r  <= WR_DATA;
         if (we_rxalm) rxalm_r <= WR_DATA;
         if (we_tliu)  tliu_r  <= WR_DATA;
         if (we_tx_config_zero)  tx_config_zero_r  <= WR_DATA;
         if (we_tx_frame_format)  tx_frame_format_r  <= WR_DATA;
         if (we_tx_manual_overhead_config)  tx_manual_overhead_config_r  <= WR_DATA;
         if (we_tx_alarm_config)  tx_alarm_config_r  <= WR_DATA;
         if (RD_EN)    rd_r    <= rd_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         {rx_s1_r, rx_s2_r}            <= 8'h00;
         {crc_d_r, crc_tog_r}          <= 2'h0;
         {loc_s1_r, loc_s2_r}          <= 2'h0;
         cfg_c_r                       <= 15'h0000;
      end else begin
         rx_s1_r   <= {RX_CRC_ERROR, RX_CAS_MF_LOSS, RX_FRAME_LOSS, RX_SIGNAL_LOSS};
         rx_s2_r   <= rx_s1_r;
         crc_d_r   <= rx_s2_r[3];
         crc_tog_r <= crc_tog_r ^ (rx_s2_r[3] & ~crc_d_r);
         loc_s1_r  <= a_loss_r;
         loc_s2_r  <= loc_s1_r;
         cfg_c_r   <= cfg_nxt;
      end
   end

   // Frame-loss integration and yellow hold-off
   always_ff @(posedge CLK) begin
      if (RESET) begin
         lof_cnt_r  <= 32'h0;
         lof_flag_r <= 1'b0;
         hold_r     <= 32'h0;
      end else if (!raw) begin
         lof_cnt_r  <= 32'h0;
         lof_flag_r <= 1'b0;
         hold_r     <= lof_flag_r ? 32'(HOLD_CYCLES) : (hold_r != 32'h0 ? hold_r - 32'h1 : hold_r);
      end else begin
         lof_cnt_r  <= lof_flag_r ? lof_cnt_r : lof_cnt_r + 32'h1;
         lof_flag_r <= lof_flag_r | (lof_cnt_r == 32'(INTEG_CYCLES - 1));
         hold_r     <= hold_r != 32'h0 ? hold_r - 32'h1 : hold_r;
      end
   end

   assign RD_DATA            = rd_r;
   assign LINE_LOOPBACK      = diag_r[0];
   assign TX_CLOCK_LOSS_FLAG = loc_s2_r;

   sequence s_hold_yel;
      yel_auto [*8];
   endsequence
   a_yel_hold_on: assert property (@(posedge CLK) disable iff (RESET)
      $fell(lof_flag_r) && integ |-> s_hold_yel)
      else $error("yellow dropped before hold time");
   a_lof_not_early: assert property (@(posedge CLK) disable iff (RESET)
      integ && raw && !lof_flag_r && lof_cnt_r < 32'(INTEG_CYCLES - 1) |=> !lof_flag_r)
      else $error("frame loss flag set before integration time");
   a_yel_follows_lof: assert property (@(posedge CLK) disable iff (RESET)
      !integ && raw && tx_alarm_config_r[`TOHG_B_AYEL] && tx_frame_format_r[`TOHG_B_YEL] ##1 raw |-> cfg_c_r[8])
      else $error("auto yellow not requested on frame loss");
   a_ais_sig_loss: assert property (@(posedge CLK) disable iff (RESET)
      tx_alarm_config_r[`TOHG_B_AAIS] && rls ##1 tx_alarm_config_r[`TOHG_B_AAIS] && rls |-> cfg_c_r[10])
      else $error("AIS not requested on signal loss");

   ////////////////////////////////////////////////////////////////////////////////////////
   // Alternate-clock domain: transmit clock loss detector and AIS output
   wire         alt_clk = tx_config_zero_r[2] ? ALT_CLOCK_IN_E1 : ALT_CLOCK_IN_T1;
   logic        arst_s1_r, arst_r, a_tg1_r, a_tg2_r, a_tg3_r, a_sel_r, a_ais_r;
   logic [1:0]  a_cf_s1_r;
   logic [3:0]  a_cnt_r;
   logic        alt_data_r, alt_act_r;
   wire         a_edge = a_tg2_r ^ a_tg3_r;
   wire [3:0]   a_cnt_nxt = (!a_sel_r || a_edge) ? 4'h0 :
                            (a_cnt_r == `TOHG_LOC_CYC) ? a_cnt_r : a_cnt_r + 4'h1;

   always_ff @(posedge alt_clk) begin
      arst_s1_r <= RESET;
      arst_r    <= arst_s1_r;
   end
   always_ff @(posedge alt_clk) begin
      if (arst_r) begin
         {a_tg1_r, a_tg2_r, a_tg3_r} <= 3'h0;
         {a_cf_s1_r, a_sel_r, a_ais_r} <= 4'h0;
         a_cnt_r <= 4'h0;
         {a_loss_r, alt_data_r, alt_act_r} <= 3'h0;
      end else begin
         a_tg1_r   <= l_tog_r;
         a_tg2_r   <= a_tg1_r;
         a_tg3_r   <= a_tg2_r;
         a_cf_s1_r <= {tliu_r[0], tx_alarm_config_r[`TOHG_B_MANUAL_AIS]};
         {a_sel_r, a_ais_r} <= a_cf_s1_r;
         a_cnt_r   <= a_cnt_nxt;
         a_loss_r  <= a_cnt_nxt == `TOHG_LOC_CYC;
         alt_act_r <= a_sel_r & (a_ais_r | a_loss_r);
         alt_data_r <= a_sel_r & (a_ais_r | a_loss_r);
      end
   end
   assign ALT_DATA   = alt_data_r;
   assign ALT_ACTIVE = alt_act_r;

   a_loss_after_eight: assert property (@(posedge alt_clk) disable iff (arst_r)
      a_sel_r && !a_edge && a_cnt_r == 4'h7 |=> a_loss_r ##1 alt_act_r)
      else $error("clock loss not flagged after eight cycles");
   a_loss_clears: assert property (@(posedge alt_clk) disable iff (arst_r)
      a_edge |=> !a_loss_r)
      else $error("clock loss kept after transmit clock returned");

   ////////////////////////////////////////////////////////////////////////////////////////
   // Line domain: frame position, overhead insertion, CRC
   logic        lrst_s1_r, lrst_r, pend_r, ldata_r, fstart_r;
   logic [2:0]  l_ct_r;
   logic [14:0] cfg_s1_r, cfg_l_r;
   logic [7:0]  pos_r;
   logic [4:0]  frm_r;
   logic [5:0]  crc_r, crch_r;
   logic        o;
   tohg_fmt_e   fmt;
   assign fmt = tohg_fmt_e'(cfg_l_r[2:0]);
   wire         fbi = cfg_l_r[3], mfi = cfg_l_r[4], crc_en = cfg_l_r[5], incf = cfg_l_r[6];
   wire         japanese_sf_yellow = cfg_l_r[7], yel = cfg_l_r[8], myel = cfg_l_r[9], ais = cfg_l_r[10];
   wire         fe1 = cfg_l_r[12], fe2 = cfg_l_r[13], man_fe = cfg_l_r[11];
   wire         auto_fe = cfg_l_r[14];
   wire         t1 = (fmt != FMT_E1) && (fmt != FMT_E1CAS);
   wire [7:0]   pm1 = pos_r - 8'h01;
   wire         fbit = t1 && (pos_r == 8'h00);
   wire [2:0]   sb = t1 ? pm1[2:0] : pos_r[2:0];
   wire [4:0]   ts = t1 ? pm1[7:3] : pos_r[7:3];
   wire         pos_last = pos_r == (t1 ? `TOHG_T1_LAST : `TOHG_E1_LAST);
   wire [4:0]   frm_last = (fmt == FMT_ESF) ? 5'h17 : t1 ? 5'h0B : 5'h0F;
   wire         ts0 = !t1 && (ts == 5'h00);
   wire         e_slot = ts0 && frm_r[0] && (sb == 3'h0) && (frm_r[3:2] == 2'h3);
   wire         e_use = e_slot && !man_fe && auto_fe;
   wire         ct_chg = l_ct_r[2] ^ l_ct_r[1];
   wire [7:0]   fas_sh = `TOHG_FAS_PAT >> (3'd7 - sb);
   wire         fas_bit = fas_sh[0];
   wire         yb2 = (fmt == FMT_ESF) || (fmt == FMT_LC) || (fmt == FMT_SF && !japanese_sf_yellow);
   wire         c_bit = ts0 && !frm_r[0] && (sb == 3'h0);
   wire         crc_skip = fbit && !incf;
   wire         blk_end = pos_last && (t1 ? frm_r == 5'h17 : frm_r[2:0] == 3'h7);
   wire [5:0]   crc_nx = crc_step(crc_r, c_bit ? 1'b0 : o, !t1);

   always_comb begin
      o = SYSTEM_PCM_TX_IN;
      if (fbit) begin
         if (fmt == FMT_ESF) begin
            if (frm_r[1:0] == 2'h3 && fbi) o = sel6(`TOHG_FPS_PAT, frm_r[4:2]);
            if (frm_r[1:0] == 2'h1 && crc_en) o = sel6(crch_r, frm_r[4:2]);
         end else if (!frm_r[0]) begin
            if (fbi) o = ~frm_r[1];
         end else begin
            if (fmt == FMT_SF && mfi) o = sel6(`TOHG_FS_PAT, frm_r[3:1]);
            if (fmt == FMT_SF && japanese_sf_yellow && yel && frm_r == 5'h0B) o = 1'b1;
         end
      end else if (ts0) begin
         if (!frm_r[0]) begin
            if (sb == 3'h0 && crc_en) o = sel6({crch_r[3:0], 2'b00}, {1'b0, frm_r[2:1]});
            if (sb != 3'h0 && fbi) o = fas_bit;
         end else if (sb == 3'h0) begin
            if (frm_r[3:2] != 2'h3) begin
               if (mfi) o = sel6(`TOHG_MF_PAT, frm_r[3:1]);
            end else if (man_fe) begin
               o = frm_r[1] ? fe2 : fe1;
            end else if (auto_fe) begin
               o = !pend_r;
            end
         end else if (sb == 3'h1 && fbi) begin
            o = 1'b1;
         end else if (sb == 3'h2 && yel) begin
            o = 1'b1;
         end
      end else if (fmt == FMT_E1CAS && ts == 5'h10 && frm_r == 5'h00 && sb == 3'h5) begin
         if (myel) o = 1'b1;
      end else if (yb2 && sb == 3'h1 && yel) begin
         o = 1'b0;
      end else if (fmt == FMT_T1DM && ts == 5'h17 && sb == 3'h5 && yel) begin
         o = 1'b0;
      end
   end

   always_ff @(posedge TX_CLOCK_IN) begin
      lrst_s1_r <= RESET;
      lrst_r    <= lrst_s1_r;
   end
   always_ff @(posedge TX_CLOCK_IN) begin
      if (lrst_r) begin
         {cfg_s1_r, cfg_l_r} <= 30'h0;
         {l_tog_r, pend_r, ldata_r, fstart_r} <= 4'h0;
         l_ct_r <= 3'h0;
         pos_r  <= 8'h00;
         frm_r  <= 5'h00;
         crc_r  <= 6'h00;
         crch_r <= 6'h00;
      end else begin
         cfg_s1_r <= cfg_c_r;
         cfg_l_r  <= cfg_s1_r;
         l_tog_r  <= ~l_tog_r;
         l_ct_r   <= {l_ct_r[1:0], crc_tog_r};
         pend_r   <= ct_chg | (pend_r & !e_use);
         pos_r    <= pos_last ? 8'h00 : pos_r + 8'h01;
         if (pos_last) frm_r <= (frm_r >= frm_last) ? 5'h00 : frm_r + 5'h01;
         if (blk_end) begin
            crch_r <= crc_nx;
            crc_r  <= 6'h00;
         end else if (!crc_skip) begin
            crc_r  <= crc_nx;
         end
         ldata_r  <= ais | o;
         fstart_r <= pos_r == 8'h00;
      end
   end
   assign LINE_DATA   = ldata_r;
   assign FRAME_START = fstart_r;

   a_ais_all_ones: assert property (@(posedge TX_CLOCK_IN) disable iff (lrst_r)
      ais ##1 ais |-> ldata_r)
      else $error("AIS not all ones");
   a_yb2_zero: assert property (@(posedge TX_CLOCK_IN) disable iff (lrst_r)
      yb2 && !fbit && sb == 3'h1 && yel && !ais |=> !ldata_r)
      else $error("bit 2 not forced low for yellow");
   a_fas_word: assert property (@(posedge TX_CLOCK_IN) disable iff (lrst_r)
      ts0 && !frm_r[0] && sb != 3'h0 && fbi && !ais |=> ldata_r == $past(fas_bit))
      else $error("FAS word bit wrong");
   a_mf_yellow: assert property (@(posedge TX_CLOCK_IN) disable iff (lrst_r)
      fmt == FMT_E1CAS && ts == 5'h10 && frm_r == 5'h00 && sb == 3'h5 && myel |=> ldata_r)
      else $error("multiframe yellow bit not set");
   a_febe_auto: assert property (@(posedge TX_CLOCK_IN) disable iff (lrst_r)
      e_use && pend_r && !ais |=> !ldata_r ##0 !pend_r || $past(ct_chg))
      else $error("pending block error not sent as zero");
endmodule

// File: tb/tohg_far_end.sv
// Far-end line terminal model: makes the line clock and collects each received frame.
// Assumes line data and the frame marker change just after the rising line clock edge.
`timescale 1ns/1ns
module tohg_far_end
   import tohg_pkg::*;
#(
   parameter int HALF_NS = 40
) (
   input  wire logic    run,
   input  wire logic    line_data,
   input  wire logic    frame_start,
   output logic         line_clk,
   output logic [255:0] last_frame,
   output int           frames
);
   logic [255:0] acc;
   int           idx;

   initial begin
      line_clk   = 1'b0;
      last_frame = '0;
      acc        = '0;
      idx        = 0;
      frames     = 0;
   end

   // Clock stands still while run is low, as when line timing is lost
   always begin
      #(HALF_NS);
      if (run === 1'b1) line_clk = ~line_clk;
   end

   // Bit 0 of a stored frame is the bit received on the same line clock edge as the marker
   always @(posedge line_clk) begin
      if (frame_start === 1'b1) begin
         last_frame = acc;
         frames     = frames + 1;
         acc        = '0;
         idx        = 0;
      end
      if (idx < 256) begin
         acc[idx] = line_data;
         idx      = idx + 1;
      end
   end
endmodule

// File: tb/tohg_tx_overhead_bench.sv
// Bench of the transmit overhead generator: registers, framing, yellow, AIS, clock loss.
// Assumes the far-end model makes the line clock and hands back whole frames.
`timescale 1ns/1ns
module tohg_tx_overhead_bench
   import tohg_pkg::*;
;
   logic         clk, reset, wr_en, rd_en, sig_loss, frm_loss, cas_loss, crc_err;
   logic         loopback, loc_flag, tx_clk, pcm, line_data, frame_start;
   logic         alt_e1, alt_t1, alt_data, alt_active, run;
   logic [6:0]   addr;
   logic [7:0]   wr_data, rd_data;
   logic [255:0] frame;
   int           frames, mismatches, checks_done, cycles;

   tohg_tx_overhead #(.INTEG_CYCLES(20), .HOLD_CYCLES(10)) tohg_tx_overhead_i (
      .CLK(clk), .RESET(reset), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
      .RD_EN(rd_en), .RD_DATA(rd_data), .RX_SIGNAL_LOSS(sig_loss), .RX_FRAME_LOSS(frm_loss),
      .RX_CAS_MF_LOSS(cas_loss), .RX_CRC_ERROR(crc_err), .LINE_LOOPBACK(loopback),
      .TX_CLOCK_LOSS_FLAG(loc_flag), .TX_CLOCK_IN(tx_clk), .SYSTEM_PCM_TX_IN(pcm),
      .LINE_DATA(line_data), .FRAME_START(frame_start), .ALT_CLOCK_IN_E1(alt_e1),
      .ALT_CLOCK_IN_T1(alt_t1), .ALT_DATA(alt_data), .ALT_ACTIVE(alt_active));
   tohg_far_end tohg_far_end_i (.run(run), .line_data(line_data), .frame_start(frame_start),
      .line_clk(tx_clk), .last_frame(frame), .frames(frames));

   always #50 clk = ~clk;
   always #37 alt_e1 = ~alt_e1;
   always #43 alt_t1 = ~alt_t1;
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
      cyc(1);
   endtask
   task automatic rd_check(input logic [6:0] a, input logic [7:0] exp);
      addr = a;
      rd_en = 1'b1;
      cyc(1);
      rd_en = 1'b0;
      check_byte(rd_data, exp);
      cyc(1);
   endtask
   task automatic wait_frames(input int n);
      int target;
      target = frames + n;
      while (frames < target) cyc(1);
   endtask
   function automatic logic [7:0] slot(input int s);
      for (int i = 0; i < 8; i++) slot[7 - i] = frame[s + i];
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_registers();
      logic [6:0] regs [9] = '{7'h14, 7'h45, 7'h47, 7'h49, 7'h68, 7'h70, 7'h72, 7'h74, 7'h75};
      foreach (regs[i]) rd_check(regs[i], 8'h00);
      rd_check(7'h00, 8'h00);
      wr(7'h47, 8'hFF);
      rd_check(7'h47, 8'h00);
      wr(7'h14, 8'h01);
      rd_check(7'h14, 8'h01);
      check_bit(loopback, 1'b1);
      wr(7'h74, 8'h07);
      rd_check(7'h74, 8'h07);
      wr(7'h74, 8'h00);
   endtask
   // Counts ones among twelve consecutive frame bits
   task automatic t_sf_bits(input logic [7:0] fmt, input logic [7:0] ins, input logic [7:0] ones);
      logic [7:0] n;
      wr(7'h70, fmt);
      wr(7'h72, ins);
      wait_frames(2);
      n = 8'h00;
      repeat (12) begin
         wait_frames(1);
         n = n + {7'h00, frame[0]};
      end
      check_byte(n, ones);
   endtask
   task automatic t_sf_yellow(input logic [7:0] ins, input logic [7:0] alm, input logic lof,
                              input logic [7:0] exp);
      wr(7'h72, ins);
      wr(7'h75, alm);
      frm_loss = lof;
      wait_frames(3);
      for (int s = 0; s < 24; s++) check_byte(slot(1 + 8 * s), exp);
   endtask
   task automatic t_integrate();
      wr(7'h45, 8'h01);
      frm_loss = 1'b1;
      cyc(5);
      rd_check(7'h47, 8'h00);
      cyc(30);
      rd_check(7'h47, 8'h02);
      frm_loss = 1'b0;
      wr(7'h45, 8'h00);
   endtask
   task automatic t_e1(input logic [7:0] alm, input logic [7:0] nfas);
      logic [7:0] b0, b1;
      wr(7'h75, alm);
      wait_frames(3);
      b0 = slot(0);
      wait_frames(1);
      b1 = slot(0);
      check_byte((b0 === 8'h1B) ? b0 : b1, 8'h1B);
      check_byte((b0 === 8'h1B) ? b1 : b0, nfas);
   endtask
   // Ones among sixteen TS0 first bits: MFAS pattern plus the two E-bits
   task automatic t_febe(input logic [7:0] man, input logic [7:0] ones);
      logic [7:0] n;
      wr(7'h74, man);
      wait_frames(2);
      n = 8'h00;
      repeat (16) begin
         wait_frames(1);
         n = n + {7'h00, frame[0]};
      end
      check_byte(n, ones);
      wr(7'h74, 8'h00);
   endtask
   task automatic t_ais(input logic [7:0] alm, input logic loss);
      logic [7:0] zc;
      wr(7'h68, {7'h00, alm[0]});
      wr(7'h75, alm);
      sig_loss = loss;
      cyc(10);
      zc = 8'h00;
      repeat (200) begin
         cyc(1);
         if (line_data !== 1'b1 && zc != 8'hFF) zc = zc + 8'h01;
      end
      check_byte(zc, 8'h00);
      check_bit(alt_active, alm[0]);
      check_bit(alt_data, alm[0]);
      rd_check(7'h47, {7'h00, loss});
      wr(7'h75, 8'h00);
      sig_loss = 1'b0;
      wr(7'h68, 8'h00);
   endtask
   task automatic t_clock_loss();
      int n;
      wr(7'h68, 8'h01);
      run = 1'b0;
      n = 0;
      while (loc_flag !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      check_bit(n >= 5 && n < 20, 1'b1);
      check_bit(alt_active, 1'b1);
      rd_check(7'h47, 8'h04);
      run = 1'b1;
      cyc(20);
      check_bit(loc_flag, 1'b0);
      check_bit(alt_active, 1'b0);
      wr(7'h68, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      alt_e1 = 1'b0;
      alt_t1 = 1'b0;
      reset = 1'b1;
      {wr_en, rd_en, sig_loss, frm_loss, cas_loss, crc_err, pcm} = 7'h00;
      addr = 7'h00;
      wr_data = 8'h00;
      run = 1'b1;
      mismatches = 0;
      checks_done = 0;
      cycles = 0;
      cyc(8);
      reset = 1'b0;
      t_registers();
      t_sf_bits(8'h00, 8'h01, 8'h03);
      t_sf_bits(8'h00, 8'h03, 8'h06);
      wr(7'h75, 8'h04);
      t_sf_bits(8'h10, 8'h01, 8'h04);
      wr(7'h70, 8'h00);
      pcm = 1'b1;
      t_sf_yellow(8'h08, 8'h08, 1'b1, 8'hBF);
      t_sf_yellow(8'h00, 8'h08, 1'b1, 8'hFF);
      t_sf_yellow(8'h00, 8'h04, 1'b0, 8'hBF);
      wr(7'h75, 8'h00);
      pcm = 1'b0;
      t_integrate();
      wr(7'h70, 8'h04);
      wr(7'h72, 8'h01);
      t_e1(8'h00, 8'h40);
      t_e1(8'h04, 8'h60);
      wr(7'h72, 8'h03);
      t_febe(8'h03, 8'h04);
      t_ais(8'h01, 1'b0);
      t_ais(8'h02, 1'b1);
      t_clock_loss();
      wrap_up();
   end
endmodule
